// File: rxf_pkg.sv
/*
 * rxf_pkg: constants and carrier types for the receive frame builder.
 * Assumes one 10 MHz clock domain shared by producer, builder and host port.
 */
package rxf_pkg;
	localparam logic [7:0] RXF_DELIM = 8'h7E;
	localparam logic [7:0] RXF_TYPE_RX = 8'h90;
	localparam logic [7:0] RXF_TYPE_EXP = 8'h91;
	localparam logic [7:0] RXF_TYPE_IO = 8'h92;
	localparam logic [15:0] RXF_RESERVED = 16'hFFFE;
	localparam logic [7:0] RXF_CKS_BASE = 8'hFF;
	localparam int RXF_OPT_EXPL_BIT = 1;
	localparam int RXF_BYTE_W = 8;
	localparam int RXF_FIFO_DEPTH = 8;
	localparam int RXF_N_ANALOG = 5;
	localparam int RXF_SUPPLY_BIT = 7;
	localparam logic [15:0] RXF_DLINE_MASK = 16'h1FFF;
	localparam logic [15:0] RXF_HDR_LEN_RX = 16'h000C;
	localparam logic [15:0] RXF_HDR_LEN_EXP = 16'h0012;
	localparam logic [15:0] RXF_HDR_LEN_IO = 16'h0010;
	localparam logic [15:0] RXF_LEN_OFS = 16'h0003;
	localparam logic [15:0] RXF_POS_ADDR = 16'h0004;
	localparam logic [1:0] RXF_ADDR_OPT = 2'h0;
	localparam logic [1:0] RXF_ADDR_MODE = 2'h1;
	localparam logic [1:0] RXF_ADDR_STAT = 2'h2;
	localparam logic [1:0] RXF_ADDR_CNT = 2'h3;

	typedef enum logic {RXF_KIND_DATA, RXF_KIND_SAMPLE} rxf_kind_e;

	typedef struct packed {
		rxf_kind_e kind;
		logic [63:0] src_addr;
		logic [7:0] src_ep;
		logic [7:0] dst_ep;
		logic [15:0] cluster;
		logic [15:0] profile;
		logic [7:0] rx_opts;
		logic [15:0] pay_len;
		logic [7:0] num_sets;
		logic [15:0] dmask;
		logic [7:0] amask;
		logic [15:0] dsample;
		logic [RXF_N_ANALOG-1:0][15:0] analog;
	} rxf_hdr_s;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rxf_reg_req_s;
endpackage : rxf_pkg

// File: rxf_frame_builder.sv
/*
 * rxf_fifo and rxf_frame_builder: payload buffer and receive frame builder.
 * Assumes header and payload producers and the host byte port share clk;
 * the producer delivers exactly pay_len payload bytes per data header.
 */
// The register offsets and the address-and-strobe port were left to the implementer.
//
// Function
// R1 - frame opens with delimiter, then 16-bit length of bytes before checksum
// R2 - last byte is FF minus low byte of sum from type onward
// R3 - option zero and radio data gives plain receive frame type 90
// R4 - plain frame carries 64-bit sender address from offset 4, then payload
// R5 - payload bytes are the received data, unmodified
// R6 - option bit 1 set gives explicit receive frame type 91
// R7 - explicit frame: endpoints at 14 and 15, cluster 16, profile 18
// R8 - option zero in frame mode forwards samples as type 92 frame
// R9 - sample frame: reserved word FFFE then receive options byte
// R10 - sample set count at offset 15
// R11 - 16-bit digital mask, lines 0 to 12, bits 13 to 15 zero
// R12 - analog mask at offset 18, inputs 0 to 3 and supply bit 7
// R13 - digital sample word only with nonzero mask, unsampled lines zero
// R14 - one 16-bit value per enabled analog input, ascending order
// R15 - multi-byte fields go most significant byte first
// R16 - host recomputes checksum and discards mismatching frames; rxf_host_model only flags a mismatch in cks_ok and keeps the frame
`timescale 1ns/10ps
`default_nettype none

module rxf_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic in_rdy;
	} rxf_fifo_s;

	rxf_fifo_s s_q;
	rxf_fifo_s s_d;
	logic push;
	logic pop;

	assign out_valid = (s_q.cnt != '0);
	assign out_data = s_q.mem[s_q.rp];
	assign in_ready = s_q.in_rdy;
	assign push = in_valid && s_q.in_rdy;
	assign pop = out_valid && out_ready;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = (s_q.wp == AW'(D - 1)) ? '0 : AW'(s_q.wp + 1'b1);
		end
		if (pop) begin
			s_d.rp = (s_q.rp == AW'(D - 1)) ? '0 : AW'(s_q.rp + 1'b1);
		end
		if (push && !pop) begin
			s_d.cnt = (AW+1)'(s_q.cnt + 1'b1);
		end else if (pop && !push) begin
			s_d.cnt = (AW+1)'(s_q.cnt - 1'b1);
		end
		s_d.in_rdy = (s_d.cnt != (AW+1)'(D));
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : rxf_fifo

////////////////////////////////////////////////////////////////////////////////

module rxf_frame_builder
	import rxf_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire rxf_reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	input wire logic hdr_valid,
	input wire rxf_hdr_s hdr,
	output logic hdr_ready,
	input wire logic pay_valid,
	input wire logic [7:0] pay_data,
	output logic pay_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready
);
	typedef enum logic {ST_IDLE, ST_FRAME} rxf_state_e;

	typedef struct packed {
		rxf_state_e st;
		rxf_hdr_s hdr;
		logic [7:0] ftype;
		logic [15:0] len;
		logic [15:0] head_end;
		logic [15:0] pos;
		logic [95:0] tail;
		logic [7:0] sum;
		logic out_valid;
		logic [7:0] out_data;
		logic [15:0] o_pos;
		logic o_cks;
		logic hdr_ready;
		logic [7:0] output_format_option;
		logic frame_mode;
		logic drop_seen;
		logic [7:0] frames;
		logic [7:0] rdata;
	} rxf_top_s;

	rxf_top_s s_q;
	rxf_top_s s_d;
	logic fifo_valid;
	logic [7:0] fifo_dout;
	logic fifo_pop;
	logic fifo_in_ready;
	logic take;
	logic hdr_take;

	rxf_fifo #(
		.W(RXF_BYTE_W),
		.D(RXF_FIFO_DEPTH)
	) u_pay_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(pay_valid),
		.in_data(pay_data),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_dout),
		.out_ready(fifo_pop)
	);

	// sample tail: digital word then enabled analog words, left justified
	function automatic logic [99:0] build_tail(input rxf_hdr_s h);
		logic [95:0] t;
		logic [3:0] n;
		int b;
		t = '0;
		n = '0;
		if (h.dmask != '0) begin // see R13
			t = {t[79:0], h.dsample & h.dmask};
			n = 4'h2;
		end
		for (int i = 0; i < RXF_N_ANALOG; i++) begin
			b = (i == RXF_N_ANALOG - 1) ? RXF_SUPPLY_BIT : i;
			if (h.amask[b]) begin // see R14
				t = {t[79:0], h.analog[i]};
				n = 4'(n + 4'h2);
			end
		end
		t = t << (8 * (12 - int'(n)));
		return {n, t};
	endfunction : build_tail

	// fixed header bytes by frame position, most significant first
	function automatic logic [7:0] head_byte(input rxf_top_s s);
		logic [7:0] b;
		logic ex;
		int p;
		ex = (s.ftype == RXF_TYPE_EXP);
		p = int'(s.pos);
		b = '0;
		case (p)
			0: b = RXF_DELIM; // see R1
			1: b = s.len[15:8]; // see R15
			2: b = s.len[7:0];
			3: b = s.ftype;
			4, 5, 6, 7, 8, 9, 10, 11: b = s.hdr.src_addr[8*(11-p) +: 8]; // see R4
			12: b = RXF_RESERVED[15:8]; // see R9
			13: b = RXF_RESERVED[7:0];
			14: b = ex ? s.hdr.src_ep : s.hdr.rx_opts; // see R7
			15: b = ex ? s.hdr.dst_ep : s.hdr.num_sets; // see R10
			16: b = ex ? s.hdr.cluster[15:8] : s.hdr.dmask[15:8]; // see R11
			17: b = ex ? s.hdr.cluster[7:0] : s.hdr.dmask[7:0];
			18: b = ex ? s.hdr.profile[15:8] : s.hdr.amask; // see R12
			19: b = s.hdr.profile[7:0];
			20: b = s.hdr.rx_opts;
			default: b = '0;
		endcase
		return b;
	endfunction : head_byte

	assign take = !s_q.out_valid || tx_ready;
	assign hdr_take = hdr_valid && s_q.hdr_ready;

	always_comb begin
		logic [99:0] tl;
		logic [7:0] b;
		logic v;
		logic cks;
		tl = '0;
		b = '0;
		v = 1'b0;
		cks = 1'b0;
		s_d = s_q;
		fifo_pop = 1'b0;

		////////////////////////////////////////////////////////////////////
		// register port
		s_d.rdata = '0;
		if (reg_req.wr) begin
			if (reg_req.addr == RXF_ADDR_OPT) begin
				s_d.output_format_option = reg_req.wdata;
			end else if (reg_req.addr == RXF_ADDR_MODE) begin
				s_d.frame_mode = reg_req.wdata[0];
			end else if (reg_req.addr == RXF_ADDR_STAT) begin
				if (reg_req.wdata[2]) begin
					s_d.drop_seen = 1'b0;
				end
			end
		end else if (reg_req.rd) begin
			if (reg_req.addr == RXF_ADDR_OPT) begin
				s_d.rdata = s_q.output_format_option;
			end else if (reg_req.addr == RXF_ADDR_MODE) begin
				s_d.rdata = {7'h00, s_q.frame_mode};
			end else if (reg_req.addr == RXF_ADDR_STAT) begin
				s_d.rdata = {5'h00, s_q.drop_seen, ~fifo_in_ready,
					s_q.st == ST_FRAME};
			end else begin
				s_d.rdata = s_q.frames;
			end
		end

		////////////////////////////////////////////////////////////////////
		// header acceptance and frame type choice
		if (hdr_take) begin
			s_d.hdr = hdr;
			s_d.hdr.dmask = hdr.dmask & RXF_DLINE_MASK; // see R11
			s_d.pos = '0;
			s_d.sum = '0;
			tl = build_tail(s_d.hdr);
			s_d.tail = tl[95:0];
			if (hdr.kind == RXF_KIND_DATA) begin
				s_d.st = ST_FRAME;
				if (s_q.output_format_option[RXF_OPT_EXPL_BIT]) begin
					s_d.ftype = RXF_TYPE_EXP; // see R6
					s_d.len = 16'(RXF_HDR_LEN_EXP + hdr.pay_len);
					s_d.head_end = 16'(RXF_HDR_LEN_EXP + RXF_LEN_OFS);
				end else begin
					s_d.ftype = RXF_TYPE_RX; // see R3
					s_d.len = 16'(RXF_HDR_LEN_RX + hdr.pay_len);
					s_d.head_end = 16'(RXF_HDR_LEN_RX + RXF_LEN_OFS);
				end
			end else if (s_q.output_format_option == '0 && s_q.frame_mode) begin
				s_d.st = ST_FRAME;
				s_d.ftype = RXF_TYPE_IO; // see R8
				s_d.len = 16'(RXF_HDR_LEN_IO + {12'h000, tl[99:96]});
				s_d.head_end = 16'(RXF_HDR_LEN_IO + RXF_LEN_OFS);
			end else begin
				s_d.drop_seen = 1'b1;
			end
		end

		////////////////////////////////////////////////////////////////////
		// byte emission
		if (take) begin
			if (s_q.st == ST_FRAME) begin
				if (s_q.pos < s_q.head_end) begin
					b = head_byte(s_q);
					v = 1'b1;
				end else if (s_q.pos < 16'(s_q.len + RXF_LEN_OFS)) begin
					if (s_q.hdr.kind == RXF_KIND_DATA) begin
						fifo_pop = fifo_valid;
						b = fifo_dout; // see R5
						v = fifo_valid;
					end else begin
						b = s_q.tail[95:88]; // see R14
						s_d.tail = {s_q.tail[87:0], 8'h00};
						v = 1'b1;
					end
				end else begin
					b = 8'(RXF_CKS_BASE - s_q.sum); // see R2
					cks = 1'b1;
					v = 1'b1;
					s_d.st = ST_IDLE;
					s_d.frames = 8'(s_q.frames + 8'h01);
				end
			end
			s_d.out_valid = v;
			if (v) begin
				s_d.out_data = b;
				s_d.o_pos = s_q.pos;
				s_d.o_cks = cks;
				s_d.pos = 16'(s_q.pos + 16'h0001);
				if (!cks && s_q.pos >= RXF_LEN_OFS) begin
					s_d.sum = 8'(s_q.sum + b); // see R2
				end
			end
		end
		s_d.hdr_ready = (s_d.st == ST_IDLE);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign hdr_ready = s_q.hdr_ready;
	assign pay_ready = fifo_in_ready;
	assign tx_valid = s_q.out_valid;
	assign tx_data = s_q.out_data;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_delim;
		tx_valid && s_q.o_pos == '0 && !s_q.o_cks |-> tx_data == RXF_DELIM;
	endproperty
	a_delim: assert property (p_delim) else $error("bad delimiter"); // see R1

	property p_len;
		tx_valid && s_q.o_pos == 16'h0001 |-> tx_data == s_q.len[15:8];
	endproperty
	a_len: assert property (p_len) else $error("bad length byte"); // see R15

	property p_cks;
		tx_valid && s_q.o_cks && s_q.pos == 16'(s_q.o_pos + 16'h0001)
			|-> tx_data == 8'(RXF_CKS_BASE - s_q.sum);
	endproperty
	a_cks: assert property (p_cks) else $error("bad checksum"); // see R2

	property p_type_rx;
		hdr_take && hdr.kind == RXF_KIND_DATA
			&& s_q.output_format_option == '0 |=> s_q.ftype == RXF_TYPE_RX;
	endproperty
	a_type_rx: assert property (p_type_rx) else $error("not plain"); // see R3

	property p_type_exp;
		hdr_take && hdr.kind == RXF_KIND_DATA
			&& s_q.output_format_option[RXF_OPT_EXPL_BIT]
			|=> s_q.ftype == RXF_TYPE_EXP && s_q.st == ST_FRAME;
	endproperty
	a_type_exp: assert property (p_type_exp) else $error("not explicit"); // see R6

	property p_type_io;
		hdr_take && hdr.kind == RXF_KIND_SAMPLE && s_q.frame_mode
			&& s_q.output_format_option == '0
			|=> s_q.ftype == RXF_TYPE_IO && s_q.st == ST_FRAME;
	endproperty
	a_type_io: assert property (p_type_io) else $error("not sample"); // see R8

	property p_addr;
		tx_valid && s_q.o_pos == RXF_POS_ADDR |-> tx_data == s_q.hdr.src_addr[63:56];
	endproperty
	a_addr: assert property (p_addr) else $error("bad address"); // see R4

	property p_res;
		tx_valid && s_q.o_pos == 16'h000C |-> tx_data == RXF_RESERVED[15:8];
	endproperty
	a_res: assert property (p_res) else $error("bad reserved"); // see R9

	property p_nsets;
		tx_valid && s_q.o_pos == 16'h000F && s_q.ftype == RXF_TYPE_IO
			|-> tx_data == s_q.hdr.num_sets;
	endproperty
	a_nsets: assert property (p_nsets) else $error("bad set count"); // see R10

	property p_amask;
		tx_valid && s_q.o_pos == 16'h0012 && s_q.ftype == RXF_TYPE_IO
			|-> tx_data == s_q.hdr.amask;
	endproperty
	a_amask: assert property (p_amask) else $error("bad analog mask"); // see R12

	property p_pay;
		fifo_pop |=> tx_valid && tx_data == $past(fifo_dout);
	endproperty
	a_pay: assert property (p_pay) else $error("payload altered"); // see R5

	property p_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_hold: assert property (p_hold) else $error("byte dropped"); // see R15

	c_rx: cover property (tx_valid && s_q.o_cks && s_q.ftype == RXF_TYPE_RX);
	c_exp: cover property (tx_valid && s_q.o_cks && s_q.ftype == RXF_TYPE_EXP);
	c_io: cover property (tx_valid && s_q.o_cks && s_q.ftype == RXF_TYPE_IO);
	c_full: cover property (!pay_ready ##1 tx_valid && !tx_ready);
endmodule : rxf_frame_builder

`default_nettype wire

// File: rxf_host_model.sv
/*
 * rxf_host_model: host reading the frame byte stream.
 * Assumes the builder byte port on the shared clk; slow halves tx_ready.
 */
`timescale 1ns/10ps
`default_nettype none

module rxf_host_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output var logic tx_ready,
	output var int frames,
	output var logic cks_ok
);
	logic [7:0] frame_q[$];
	logic [7:0] last_q[$];
	logic [7:0] sum;
	int need;

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (!rst_n) begin
			tx_ready <= 1'b0;
			frames <= 0;
			cks_ok <= 1'b0;
			need = 0;
			frame_q.delete();
		end else begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
			if (tx_valid && tx_ready) begin
				if (frame_q.size() != 0 || tx_data == 8'h7E) begin
					frame_q.push_back(tx_data);
				end
				if (frame_q.size() == 3) begin
					need = {frame_q[1], frame_q[2]} + 4;
				end
				if (frame_q.size() > 3 && frame_q.size() == need) begin
					sum = 8'h00;
					for (int i = 3; i < need - 1; i++) begin
						sum = sum + frame_q[i];
					end
					cks_ok <= (8'hFF - sum) == tx_data;
					last_q = frame_q;
					frame_q.delete();
					frames <= frames + 1;
				end
			end
		end
	end
endmodule : rxf_host_model

`default_nettype wire

// File: rxf_frame_builder_tb_top.sv
/*
 * rxf_frame_builder_tb_top: directed bench for the receive frame builder.
 * Assumes rxf_pkg and rxf_host_model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module rxf_frame_builder_tb_top
	import rxf_pkg::*;
;
	logic clk, rst_n, hdr_valid, hdr_ready, pay_valid, pay_ready;
	logic tx_valid, tx_ready, slow, cks_ok, saw_full;
	logic [7:0] reg_rdata, pay_data, tx_data;
	rxf_reg_req_s reg_req;
	rxf_hdr_s hdr, h;
	int frames, mismatches, samples_checked, cyc, nfr;
	logic [7:0] body[$];
	logic [7:0] exp_q[$];

	rxf_frame_builder uut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .hdr_valid(hdr_valid), .hdr(hdr),
		.hdr_ready(hdr_ready), .pay_valid(pay_valid), .pay_data(pay_data),
		.pay_ready(pay_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready));
	rxf_host_model host (.clk(clk), .rst_n(rst_n), .slow(slow),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.frames(frames), .cks_ok(cks_ok));

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		reg_req.wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		reg_req.rd <= 1'b0;
		#1 chk(16'(reg_rdata), 16'(e));
	endtask : reg_rd

	task automatic put(input logic [15:0] v, input int n);
		if (n == 2) body.push_back(v[15:8]);
		body.push_back(v[7:0]);
	endtask : put

	// expected frame from header, multi-byte fields high byte first
	task automatic expect_frame(input logic expl);
		logic [7:0] s;
		logic [15:0] dm;
		body = {};
		dm = h.dmask & 16'h1FFF;
		if (h.kind == RXF_KIND_SAMPLE) put(16'h0092, 1);
		else put(expl ? 16'h0091 : 16'h0090, 1);
		for (int i = 3; i >= 0; i--) put(h.src_addr[i*16 +: 16], 2);
		put(16'hFFFE, 2);
		if (h.kind == RXF_KIND_DATA && expl) begin
			put({h.src_ep, h.dst_ep}, 2);
			put(h.cluster, 2);
			put(h.profile, 2);
		end
		put(16'(h.rx_opts), 1);
		if (h.kind == RXF_KIND_SAMPLE) begin
			put(16'(h.num_sets), 1);
			put(dm, 2);
			put(16'(h.amask), 1);
			if (dm != 16'h0000) put(h.dsample & dm, 2);
			for (int i = 0; i < 4; i++) if (h.amask[i]) put(h.analog[i], 2);
			if (h.amask[7]) put(h.analog[4], 2);
		end else begin
			for (int i = 0; i < h.pay_len; i++) put(16'(i ^ 8'hA5), 1);
		end
		s = 8'h00;
		foreach (body[i]) s = s + body[i];
		exp_q = {8'h7E, 8'(body.size() >> 8), 8'(body.size()), body};
		exp_q.push_back(8'hFF - s);
	endtask : expect_frame

	task automatic send_hdr();
		hdr <= h;
		hdr_valid <= 1'b1;
		do @(posedge clk); while (!hdr_ready);
		hdr_valid <= 1'b0;
	endtask : send_hdr

	task automatic send_pay(input int n);
		for (int i = 0; i < n; i++) begin
			pay_valid <= 1'b1;
			pay_data <= 8'(i ^ 8'hA5);
			do begin
				@(posedge clk);
				if (!pay_ready) saw_full = 1'b1;
			end while (!pay_ready);
		end
		pay_valid <= 1'b0;
	endtask : send_pay

	task automatic run(input logic expl);
		int n0, k;
		n0 = frames;
		expect_frame(expl);
		@(posedge clk);
		fork
			send_hdr();
			if (h.kind == RXF_KIND_DATA) send_pay(h.pay_len);
		join
		k = 0;
		while (frames == n0 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		#1 chk(16'(frames - n0), 16'h0001);
		chk(16'(host.last_q.size()), 16'(exp_q.size()));
		foreach (exp_q[i]) chk(16'(host.last_q[i]), 16'(exp_q[i]));
		chk(16'(cks_ok), 16'h0001);
		nfr++;
	endtask : run

	function automatic rxf_hdr_s mk(input rxf_kind_e kd, input logic [15:0] n);
		rxf_hdr_s r;
		r = '0;
		r.kind = kd;
		r.src_addr = 64'h0102_0304_0506_0708;
		r.src_ep = 8'hE8;
		r.dst_ep = 8'h5A;
		r.cluster = 16'h1234;
		r.profile = 16'hC0DE;
		r.rx_opts = 8'h03;
		r.pay_len = n;
		r.num_sets = 8'h01;
		for (int i = 0; i < 5; i++) r.analog[i] = 16'h0200 + 16'(i * 17);
		return r;
	endfunction : mk

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		reg_req = '0;
		hdr_valid = 1'b0;
		hdr = '0;
		pay_valid = 1'b0;
		pay_data = 8'h00;
		slow = 1'b0;
		saw_full = 1'b0;
		repeat (20) @(posedge clk);
		chk(16'({hdr_ready, tx_valid, pay_ready}), 16'h0000);
		rst_n <= 1'b1;
		reg_rd(RXF_ADDR_OPT, 8'h00);
		reg_rd(RXF_ADDR_STAT, 8'h00);
		// plain data, option zero and option without bit 1
		h = mk(RXF_KIND_DATA, 16'd3);
		run(1'b0);
		reg_wr(RXF_ADDR_OPT, 8'h01);
		h = mk(RXF_KIND_DATA, 16'd0);
		run(1'b0);
		// explicit, payload above FIFO depth, slow host
		reg_wr(RXF_ADDR_OPT, 8'h02);
		slow <= 1'b1;
		h = mk(RXF_KIND_DATA, 16'd12);
		run(1'b1);
		chk(16'(saw_full), 16'h0001);
		slow <= 1'b0;
		// sample dropped while option nonzero
		reg_wr(RXF_ADDR_MODE, 8'h01);
		h = mk(RXF_KIND_SAMPLE, 16'd0);
		send_hdr();
		reg_rd(RXF_ADDR_STAT, 8'h04);
		reg_wr(RXF_ADDR_STAT, 8'h04);
		reg_rd(RXF_ADDR_STAT, 8'h00);
		// samples: all lines and inputs, then analog only
		reg_wr(RXF_ADDR_OPT, 8'h00);
		h = mk(RXF_KIND_SAMPLE, 16'd0);
		h.dmask = 16'hFFFF;
		h.dsample = 16'hA5C3;
		h.amask = 8'h8F;
		run(1'b0);
		h.dmask = 16'h0000;
		h.amask = 8'h06;
		h.rx_opts = 8'h02;
		run(1'b0);
		// sample dropped in transparent mode
		reg_wr(RXF_ADDR_MODE, 8'h00);
		send_hdr();
		reg_rd(RXF_ADDR_STAT, 8'h04);
		chk(16'(frames), 16'(nfr));
		reg_rd(RXF_ADDR_CNT, 8'(nfr));
		end_sim();
	end
endmodule : rxf_frame_builder_tb_top

`default_nettype wire
